/* File: dv/dbsm_chk.sv */
// Port timing checker for the semaphore and mailbox block
`timescale 1ns/10ps
`default_nettype none
module dbsm_chk
#(
   parameter RAM_AW = 7
)
(
   input wire logic              i_clock,
   input wire logic              i_nrst,
   input wire logic              i_sys_sel,
   input wire logic              i_sys_sem_sel,
   input wire logic              i_sys_we,
   input wire logic [RAM_AW-1:0] i_sys_addr,
   input wire logic [7:0]        o_sys_rdata,
   input wire logic              o_sys_ack,
   input wire logic              i_loc_sel,
   input wire logic              i_loc_sem_sel,
   input wire logic              i_loc_we,
   input wire logic [RAM_AW-1:0] i_loc_addr,
   input wire logic [7:0]        o_loc_rdata,
   input wire logic              o_loc_ack
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_nrst);
   // Semaphore reads of each side and writes of the system side
   wire logic sr = i_sys_sel & i_sys_sem_sel & ~i_sys_we;
   wire logic sw = i_sys_sel & i_sys_sem_sel & i_sys_we;
   wire logic lr = i_loc_sel & i_loc_sem_sel & ~i_loc_we;
   chk_sys_ack: assert property (i_sys_sel |=> o_sys_ack) else $error("sys ack");
   chk_loc_ack: assert property (o_loc_ack |-> $past(i_loc_sel)) else $error("loc ack");
   chk_sys_pad: assert property (sr |-> ##2 o_sys_rdata[5:0] == 6'h00) else $error("pad");
   chk_loc_pad: assert property (lr |-> ##2 o_loc_rdata[5:0] == 6'h00) else $error("pad");
   chk_set_own: assert property ((sr && !i_loc_sel) ##1 (sr && !i_loc_sel
      && i_sys_addr < 6 && i_sys_addr == $past(i_sys_addr)) ##1 !o_sys_rdata[7]
      |=> o_sys_rdata[7:6] == 2'b11) else $error("set");
   chk_wr_clear: assert property ((sw && !i_loc_sel) ##1 (sr && !i_loc_sel
      && i_sys_addr == $past(i_sys_addr)) |-> ##2 !o_sys_rdata[7]) else $error("clear");
   chk_one_wins: assert property (sr && lr && i_sys_addr == i_loc_addr && i_sys_addr < 6
      |-> ##2 o_sys_rdata[7] || o_loc_rdata[7]) else $error("both won");
   chk_high_index: assert property (sr && i_sys_addr > 5 |-> ##2 o_sys_rdata == 8'h00)
      else $error("index");
endmodule
bind dbsm_top dbsm_chk #(.RAM_AW(RAM_AW)) chk (.*);
`default_nettype wire

/* File: dv/dbsm_master.sv */
// Bus master model for one side of the block
`timescale 1ns/10ps
`default_nettype none
module dbsm_master (
   output var logic       o_sel,
   output var logic       o_sem_sel,
   output var logic       o_we,
   output var logic [6:0] o_addr,
   output var logic [7:0] o_wdata
);
   initial {o_sel, o_sem_sel, o_we, o_addr, o_wdata} = 18'h00000;
   // Idle lines toggle so stale values never pass for held ones
   task put(input logic [2:0] c, input logic [6:0] a, input logic [7:0] d);
      {o_sel, o_sem_sel, o_we} <= c;
      o_addr  <= c[2] ? a : ~o_addr;
      o_wdata <= c[2] ? d : ~o_wdata;
   endtask
   // Cleared lock in a read byte means acquired
   function bit got(input logic [7:0] r);
      return !r[7];
   endfunction
endmodule
`default_nettype wire

/* File: dv/dbsm_top_test.sv */
// Self-checking bench for the semaphore and mailbox block
`timescale 1ns/10ps
`default_nettype none
`define CK(n, e, v) begin checked++; if ((v) !== (e)) begin fail_count++; \
   $display("unexpected %s exp %h got %h", n, e, v); end end
module dbsm_top_test;
   logic            i_clock = 1'b0;
   logic            i_nrst  = 1'b0;
   logic [2:0]      sc, lc;
   wire logic       s_sel, s_sem, s_we, l_sel, l_sem, l_we, o_sys_ack, o_loc_ack;
   wire logic [6:0] s_a, l_a;
   wire logic [7:0] s_d, l_d, o_sys_rdata, o_loc_rdata;
   bit              lock[6], own[6], ps, pl;
   int              mem[128], e1s, e2s, e1l, e2l, es, el, checked, fail_count, cyc;
   dbsm_master ms (.o_sel(s_sel), .o_sem_sel(s_sem), .o_we(s_we), .o_addr(s_a), .o_wdata(s_d));
   dbsm_master ml (.o_sel(l_sel), .o_sem_sel(l_sem), .o_we(l_we), .o_addr(l_a), .o_wdata(l_d));
   dbsm_top DUT (.i_clock, .i_nrst, .i_sys_sel(s_sel), .i_sys_sem_sel(s_sem), .i_sys_we(s_we),
      .i_sys_addr(s_a), .i_sys_wdata(s_d), .o_sys_rdata, .o_sys_ack, .i_loc_sel(l_sel),
      .i_loc_sem_sel(l_sem), .i_loc_we(l_we), .i_loc_addr(l_a), .i_loc_wdata(l_d),
      .o_loc_rdata, .o_loc_ack);
   always #5 i_clock = ~i_clock;
   // Hang guard, far above the run length
   always @(posedge i_clock)
   begin
      cyc++;
      if (cyc == 4000)
      begin
         fail_count++;
         summarize;
      end
   end
   // Reference: system side served first; unwritten memory is not compared
   task mdl(input bit s, input logic [2:0] c, input logic [6:0] a, output int e);
      e = -1;
      if (c == 3'b110) e = a < 6 ? {lock[a], own[a] == s, 6'h00} : 0;
      if (c == 3'b100) e = mem[a];
      if (c[2] && c[1] && a < 6)
      begin
         if (!c[0] && !lock[a]) own[a] = s;
         lock[a] = !c[0];
      end
   endtask
   // One cycle on both buses, checking the answers of earlier cycles
   task step(input logic [2:0] c, d, input logic [6:0] sa, la, input logic [7:0] sd, ld);
      if (c[1]) sa = sa % 8;
      if (d[1]) la = la % 8;
      @(posedge i_clock);
      ms.put(c, sa, sd);
      ml.put(d, la, ld);
      mdl(1, c, sa, es);
      mdl(0, d, la, el);
      if (c == 3'b101) mem[sa] = sd;
      if (d == 3'b101) mem[la] = ld;
      #1;
      `CK("sys ack", ps, o_sys_ack)
      `CK("loc ack", pl, o_loc_ack)
      if (e2s >= 0) `CK("sys data", e2s[7:0], o_sys_rdata)
      if (e2l >= 0) `CK("loc data", e2l[7:0], o_loc_rdata)
      {ps, pl, e2s, e1s, e2l, e1l} = {c[2], d[2], e1s, es, e1l, el};
   endtask
   task rst;
      @(posedge i_clock);
      // Idle both buses, or a request left from the last round is taken after release
      ms.put(0, 0, 0);
      ml.put(0, 0, 0);
      i_nrst <= 1'b0;
      repeat (3) @(posedge i_clock);
      i_nrst <= 1'b1;
      foreach (lock[i]) {lock[i], own[i]} = {1'b1, i == 2};
      foreach (mem[i]) mem[i] = -1;
      {ps, pl, e1s, e2s, e1l, e2l} = {2'b00, {4{-32'sd1}}};
   endtask
   task summarize;
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      void'($urandom(45882));
      for (int r = 0; r < 2; r++)
      begin
         rst;
         for (int i = 0; i < 6; i++) step(3'b110, 3'b110, 7'(i), 7'(i), 0, 0);
         for (int i = 0; i < 8; i++) step(0, 3'b111, 0, 7'(i), 0, 8'($urandom));
         for (int i = 0; i < 6; i++) step(3'b110, 3'b110, 7'(i), 7'(i), 0, 0);
         for (int i = 0; i < 18; i++) step(i % 3 ? 3'b110 : 3'b111, 0, 7'(i / 3), 0, 0, 0);
         step(3'b111, 0, 7'(4), 0, 0, 0);
         step(3'b110, 3'b110, 7'(4), 7'(4), 0, 0);
         repeat (2) step(0, 0, 0, 0, 0, 0);
         `CK("one winner", 2'd1, ms.got(o_sys_rdata) + ml.got(o_loc_rdata))
         for (int i = 0; i < 400; i++)
         begin
            sc = 3'($urandom);
            lc = 3'($urandom);
            step(sc, lc, 7'($urandom), 7'($urandom), 8'($urandom), 8'($urandom));
         end
         $display("round %0d finished", r);
      end
      repeat (3) step(0, 0, 0, 0, 0, 0);
      summarize;
   end
endmodule
`default_nettype wire

/* File: verilog/dbsm_defines.vh */
// Constants for the dual bus semaphore and mailbox block
`ifndef DBSM_DEFINES_VH
`define DBSM_DEFINES_VH
// Number of semaphore registers
`define DBSM_SEM_COUNT      6
// Shared memory depth in bytes and its address width
`define DBSM_RAM_DEPTH      128
`define DBSM_RAM_AW         7
// Semaphore register field positions
`define DBSM_LOCK_BIT       7
`define DBSM_OWNER_BIT      6
// Semaphore reset: every lock set, local side owns all but number 2
`define DBSM_LOCK_RESET     6'h3f
`define DBSM_OWNER_RESET    6'h04
// Reset value of read data ports
`define DBSM_RDATA_RESET    8'h00
`endif

/* File: verilog/dbsm_dpram.v */
// Shared dual-port byte memory with registered read data per port
`timescale 1ns/10ps
`default_nettype none
module dbsm_dpram
#(
   parameter DEPTH = 128,
   parameter AW    = 7
)
(
   input  wire          i_clock,
   input  wire          i_a_we,
   input  wire [AW-1:0] i_a_addr,
   input  wire [7:0]    i_a_wdata,
   output reg  [7:0]    o_a_rdata,
   input  wire          i_b_we,
   input  wire [AW-1:0] i_b_addr,
   input  wire [7:0]    i_b_wdata,
   output reg  [7:0]    o_b_rdata
);
   reg [7:0] mem [0:DEPTH-1];

   // Both ports share one array; on a same-address collision port b's write wins
   always @(posedge i_clock)
   begin
      if (i_a_we)
         mem[i_a_addr] <= i_a_wdata;
      if (i_b_we)
         mem[i_b_addr] <= i_b_wdata;
      o_a_rdata <= mem[i_a_addr];
      o_b_rdata <= mem[i_b_addr];
   end
endmodule
`default_nettype wire

/* File: verilog/dbsm_top.v */
// Dual bus semaphore bank and shared mailbox memory
//
// Contract
// - Six semaphores, reachable from both buses
// - 128 byte memory shared by both buses
// - System accesses never disturb the local bus
// - Eight bits: lock bit 7, owner bit 6
// - Bits five to zero always read zero
// - Atomic test-and-set; simultaneous accesses serialized
// - Read returns old lock, then lock set
// - Any write ignores data, clears lock
// - Owner bit read-only, shows last setter
// - Reset: locks set, local owns except two
`timescale 1ns/10ps
`default_nettype none
`include "dbsm_defines.vh"
module dbsm_top
#(
   parameter SEM_COUNT = `DBSM_SEM_COUNT,
   parameter RAM_DEPTH = `DBSM_RAM_DEPTH,
   parameter RAM_AW    = `DBSM_RAM_AW
)
(
   input  wire              i_clock,
   input  wire              i_nrst,
   // System bus port
   input  wire              i_sys_sel,
   input  wire              i_sys_sem_sel,
   input  wire              i_sys_we,
   input  wire [RAM_AW-1:0] i_sys_addr,
   input  wire [7:0]        i_sys_wdata,
   output reg  [7:0]        o_sys_rdata,
   output reg               o_sys_ack,
   // Local bus port
   input  wire              i_loc_sel,
   input  wire              i_loc_sem_sel,
   input  wire              i_loc_we,
   input  wire [RAM_AW-1:0] i_loc_addr,
   input  wire [7:0]        i_loc_wdata,
   output reg  [7:0]        o_loc_rdata,
   output reg               o_loc_ack
);
   // ****************************************************************
   // Semaphore state
   // ****************************************************************
   reg [SEM_COUNT-1:0] lock_r;
   reg [SEM_COUNT-1:0] lock_nxt;
   reg [SEM_COUNT-1:0] owner_sys_r;   // 1 = system side set it last
   reg [SEM_COUNT-1:0] owner_sys_nxt;
   reg [7:0]           sys_sem_nxt;
   reg [7:0]           loc_sem_nxt;
   reg                 sys_sem_q;
   reg                 loc_sem_q;
   reg [7:0]           sys_sem_r;
   reg [7:0]           loc_sem_r;
   wire [7:0]          sys_ram_rd;
   wire [7:0]          loc_ram_rd;

   // Index valid check shared by both ports
   function sem_hit;
      input [RAM_AW-1:0] addr;
      begin
         sem_hit = (addr < SEM_COUNT);
      end
   endfunction

   // Format a semaphore byte; low six bits are always zero
   function [7:0] sem_byte;
      input lock;
      input own;
      begin
         sem_byte = {lock, own, 6'h00};
      end
   endfunction

   // ****************************************************************
   // Address decode
   // ****************************************************************
   // Only the low three address bits index the bank; the range check
   // on the whole address keeps a high index from aliasing onto it.
   reg                 sys_sem_acc;
   reg                 loc_sem_acc;
   reg                 sys_ram_we;
   reg                 loc_ram_we;
   wire [2:0]          sys_idx = i_sys_addr[2:0];
   wire [2:0]          loc_idx = i_loc_addr[2:0];

   // System bus: semaphore space, memory space or nothing this cycle
   always @*
   begin
      sys_sem_acc = 1'b0;
      sys_ram_we  = 1'b0;
      if (!i_sys_sel)
         sys_sem_acc = 1'b0;
      else if (i_sys_sem_sel)
         sys_sem_acc = sem_hit(i_sys_addr);
      else if (i_sys_we)
         sys_ram_we  = 1'b1;
   end

   // Local bus: a decode of its own, so no system cycle touches it
   always @*
   begin
      loc_sem_acc = 1'b0;
      loc_ram_we  = 1'b0;
      if (!i_loc_sel)
         loc_sem_acc = 1'b0;
      else if (i_loc_sem_sel)
         loc_sem_acc = sem_hit(i_loc_addr);
      else if (i_loc_we)
         loc_ram_we  = 1'b1;
   end

   // ****************************************************************
   // Test-and-set arbitration
   // ****************************************************************
   // Both accesses resolve in one combinational pass; system side goes
   // first, so a local access to the same semaphore sees its result.
   always @*
   begin
      lock_nxt      = lock_r;
      owner_sys_nxt = owner_sys_r;
      sys_sem_nxt   = 8'h00;
      loc_sem_nxt   = 8'h00;
      if (sys_sem_acc)
      begin
         sys_sem_nxt = sem_byte(lock_nxt[sys_idx], owner_sys_nxt[sys_idx]);
         if (i_sys_we)
            lock_nxt[sys_idx] = 1'b0;
         else
         begin
            if (!lock_nxt[sys_idx])
               owner_sys_nxt[sys_idx] = 1'b1;
            lock_nxt[sys_idx] = 1'b1;
         end
      end
      if (loc_sem_acc)
      begin
         loc_sem_nxt = sem_byte(lock_nxt[loc_idx], ~owner_sys_nxt[loc_idx]);
         if (i_loc_we)
            lock_nxt[loc_idx] = 1'b0;
         else
         begin
            if (!lock_nxt[loc_idx])
               owner_sys_nxt[loc_idx] = 1'b0;
            lock_nxt[loc_idx] = 1'b1;
         end
      end
   end

   // Semaphore registers and registered answers; the answer byte is
   // captured with the state, so both describe the same access order
   always @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         lock_r      <= `DBSM_LOCK_RESET;
         owner_sys_r <= `DBSM_OWNER_RESET;
         sys_sem_r   <= `DBSM_RDATA_RESET;
         loc_sem_r   <= `DBSM_RDATA_RESET;
         sys_sem_q   <= 1'b0;
         loc_sem_q   <= 1'b0;
         o_sys_ack   <= 1'b0;
         o_loc_ack   <= 1'b0;
      end
      else
      begin
         lock_r      <= lock_nxt;
         owner_sys_r <= owner_sys_nxt;
         sys_sem_r   <= sys_sem_nxt;
         loc_sem_r   <= loc_sem_nxt;
         sys_sem_q   <= i_sys_sel & i_sys_sem_sel;
         loc_sem_q   <= i_loc_sel & i_loc_sem_sel;
         o_sys_ack   <= i_sys_sel;
         o_loc_ack   <= i_loc_sel;
      end
   end

   // ****************************************************************
   // Shared memory
   // ****************************************************************
   // Each bus owns its port, so system traffic never reaches local pins
   // Same-cycle writes to one byte: the local port wins
   dbsm_dpram
   #(
      .DEPTH (RAM_DEPTH),
      .AW    (RAM_AW)
   )
   u_ram
   (
      .i_clock   (i_clock),
      .i_a_we    (sys_ram_we),
      .i_a_addr  (i_sys_addr),
      .i_a_wdata (i_sys_wdata),
      .o_a_rdata (sys_ram_rd),
      .i_b_we    (loc_ram_we),
      .i_b_addr  (i_loc_addr),
      .i_b_wdata (i_loc_wdata),
      .o_b_rdata (loc_ram_rd)
   );

   // ****************************************************************
   // Read data outputs
   // ****************************************************************
   // Data follows ack by one cycle; a combinational mux would break the
   // flop-only output style, so the mux result is registered again.
   always @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_sys_rdata <= `DBSM_RDATA_RESET;
         o_loc_rdata <= `DBSM_RDATA_RESET;
      end
      else
      begin
         o_sys_rdata <= sys_sem_q ? sys_sem_r : sys_ram_rd;
         o_loc_rdata <= loc_sem_q ? loc_sem_r : loc_ram_rd;
      end
   end
endmodule
`default_nettype wire
